/* design/vme_master_requester_control_regs.vh */
// constants of the master requester control block
// assumes a 40 MHz clock and one word-wide control register
`ifndef VME_MASTER_REQUESTER_CONTROL_REGS_VH
`define VME_MASTER_REQUESTER_CONTROL_REGS_VH

// byte address of the control register
`define VMC_OFFSET 12'h234
`define VMC_RESET 32'h0000_0003

// field positions
`define VMC_STOP_ACK 27
`define VMC_STOP_REQ 26
`define VMC_GRANTED 25
`define VMC_HOLD_REQ 24
`define VMC_ATOMIC 20
`define VMC_WIDE_DS 16
`define VMC_BACKOFF_HI 14
`define VMC_BACKOFF_LO 12
`define VMC_TENURE_HI 10
`define VMC_TENURE_LO 8
`define VMC_REL_HI 4
`define VMC_REL_LO 3
`define VMC_FAIR 2
`define VMC_LEVEL_HI 1
`define VMC_LEVEL_LO 0

// reset values of the fields
`define VMC_BACKOFF_RST 3'h0
`define VMC_TENURE_RST 3'h0
`define VMC_REL_RST 2'h0
`define VMC_LEVEL_RST 2'h3

// release policy codes
`define REL_TENURE_OR_DONE 2'h0
`define REL_TENURE_REQ 2'h1
`define REL_TENURE_BCLR 2'h2
`define REL_AND_REQ 2'h3

// timing
`define CLK_PERIOD_NS 25
`define US_NS 1000
// cycles per microsecond at the 25 ns clock
`define CYC_PER_US 8'h28
`define TENURE_MIN_US 10'h004
`define TENURE_MIN_BYTES 13'h0080
`define TENURE_BYTE_CODE_BASE 3'h2

`endif

/* design/vme_master_requester_control.v */
// master requester control: acquire, hold, throttle and release the bus
// assumes an AHB-Lite master with single word transfers and
// arbitration inputs already synchronous to mclk_in
//
// The AHB-Lite interface to the registers is this design's own decision.
`include "vme_master_requester_control_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module vme_master_requester_control #(
	parameter [7:0] US_CYCLES = `CYC_PER_US
) (
	input wire mclk_in,
	input wire reset_n_in,
	input wire local_reset_input_n_in,
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output reg [31:0] hrdata_out,
	output reg hreadyout_out,
	output reg hresp_out,
	input wire channel_req_in,
	input wire dma_req_in,
	output reg initiator_grant_out,
	input wire bus_grant_in,
	input wire [3:0] other_req_in,
	input wire bus_clear_in,
	output reg [3:0] bus_req_out,
	output reg bus_busy_out,
	output reg fair_mode_out,
	input wire xfer_2e_in,
	input wire beat_in,
	input wire [3:0] beat_bytes_in,
	input wire a64_addr_phase_in,
	input wire [1:0] data_strobe_sel_in,
	output reg [1:0] data_strobe_out,
	input wire rmw_compare_done_in,
	input wire rmw_match_in,
	output reg atomic_enable_out,
	output reg rmw_swap_write_out
);

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_REQ = 2'd1;
	localparam [1:0] ST_OWN = 2'd2;
	localparam [1:0] ST_BACKOFF = 2'd3;
	localparam [7:0] US_LAST = US_CYCLES - 8'd1;

	reg stop_request;
	reg hold_request;
	reg stop_ack_flag;
	reg ownership_granted_flag;
	reg atomic_cycle_enable;
	reg wide_addr_strobe_both;
	reg [2:0] backoff_interval;
	reg [2:0] tenure_limit;
	reg [1:0] release_policy;
	reg fair_request_mode;
	reg [1:0] request_level_select;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] prescale;
	reg [9:0] tenure_us;
	reg [12:0] tenure_bytes;
	reg [6:0] backoff_us;
	reg wr_pend;
	reg release_ok;
	wire local_reset;
	wire us_tick;
	wire init_pend;
	wire done;
	wire other_req;
	wire level_busy;
	wire want;
	wire [9:0] tenure_lim_us;
	wire [12:0] tenure_lim_bytes;
	wire [6:0] backoff_lim;
	wire tenure_exp;
	wire addr_hit;
	wire [31:0] reg_value;

	assign local_reset = ~local_reset_input_n_in;
	assign us_tick = (prescale == US_LAST);
	// a stop request keeps internal initiators off the bus
	assign init_pend = (channel_req_in | dma_req_in) & ~stop_request;
	assign done = ~(channel_req_in | dma_req_in);
	assign other_req = |other_req_in;
	assign level_busy = other_req_in[request_level_select];
	assign want = stop_request | hold_request | init_pend;

	assign tenure_lim_us = `TENURE_MIN_US << tenure_limit;
	assign tenure_lim_bytes = (tenure_limit <= `TENURE_BYTE_CODE_BASE) ?
		`TENURE_MIN_BYTES :
		(`TENURE_MIN_BYTES << (tenure_limit - `TENURE_BYTE_CODE_BASE));
	assign backoff_lim = (backoff_interval == 3'h0) ? 7'h00 :
		(7'h01 << (backoff_interval - 3'h1));
	assign tenure_exp = xfer_2e_in ? (tenure_bytes >= tenure_lim_bytes) :
		(tenure_us >= tenure_lim_us);

	assign addr_hit = (haddr_in[11:0] == `VMC_OFFSET);
	assign reg_value = {4'h0, stop_ack_flag, stop_request,
		ownership_granted_flag, hold_request, 3'h0, atomic_cycle_enable,
		3'h0, wide_addr_strobe_both, 1'b0, backoff_interval, 1'b0,
		tenure_limit, 3'h0, release_policy, fair_request_mode,
		request_level_select};

	// release condition per policy
	always @* begin
		case (release_policy)
		`REL_TENURE_OR_DONE: release_ok = tenure_exp | done;
		`REL_TENURE_REQ: release_ok = (tenure_exp & other_req) | done;
		`REL_TENURE_BCLR: release_ok = (tenure_exp & bus_clear_in) | done;
		`REL_AND_REQ: release_ok = (tenure_exp | done) & other_req;
		default: release_ok = 1'b0;
		endcase
	end

	always @* begin
		next_state = state;
		if (local_reset) begin
			next_state = ST_IDLE;
		end else begin
			case (state)
			ST_IDLE: begin
				// fair mode waits until the level is idle
				if (want && !(fair_request_mode && level_busy)) begin
					next_state = ST_REQ;
				end
			end
			ST_REQ: begin
				if (bus_grant_in) begin
					next_state = ST_OWN;
				end else if (!want) begin
					next_state = ST_IDLE;
				end
			end
			ST_OWN: begin
				// stop or hold keeps the bus regardless of throttling
				if (!stop_request && !hold_request && release_ok) begin
					next_state = tenure_exp ? ST_BACKOFF : ST_IDLE;
				end
			end
			ST_BACKOFF: begin
				if (backoff_us >= backoff_lim) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
			endcase
		end
	end

	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= ST_IDLE;
			prescale <= 8'h00;
			tenure_us <= 10'h000;
			tenure_bytes <= 13'h0000;
			backoff_us <= 7'h00;
			stop_ack_flag <= 1'b0;
			ownership_granted_flag <= 1'b0;
		end else begin
			state <= next_state;
			if (next_state != state || us_tick) begin
				prescale <= 8'h00;
			end else begin
				prescale <= prescale + 8'h01;
			end
			if (state != ST_OWN) begin
				tenure_us <= 10'h000;
				tenure_bytes <= 13'h0000;
			end else if (!tenure_exp) begin
				if (us_tick) begin
					tenure_us <= tenure_us + 10'h001;
				end
				if (beat_in) begin
					tenure_bytes <= tenure_bytes + {9'h000, beat_bytes_in};
				end
			end
			if (state != ST_BACKOFF) begin
				backoff_us <= 7'h00;
			end else if (us_tick) begin
				backoff_us <= backoff_us + 7'h01;
			end
			// flags name the cause of this tenure only
			if (state == ST_REQ && next_state == ST_OWN) begin
				stop_ack_flag <= stop_request;
				ownership_granted_flag <= hold_request;
			end else if (next_state != ST_OWN) begin
				stop_ack_flag <= 1'b0;
				ownership_granted_flag <= 1'b0;
			end else begin
				stop_ack_flag <= stop_ack_flag & stop_request;
				ownership_granted_flag <= ownership_granted_flag & hold_request;
			end
		end
	end

	// register writes; local reset restores every field
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stop_request <= 1'b0;
			hold_request <= 1'b0;
			atomic_cycle_enable <= 1'b0;
			wide_addr_strobe_both <= 1'b0;
			backoff_interval <= `VMC_BACKOFF_RST;
			tenure_limit <= `VMC_TENURE_RST;
			release_policy <= `VMC_REL_RST;
			fair_request_mode <= 1'b0;
			request_level_select <= `VMC_LEVEL_RST;
		end else if (local_reset) begin
			stop_request <= 1'b0;
			hold_request <= 1'b0;
			atomic_cycle_enable <= 1'b0;
			wide_addr_strobe_both <= 1'b0;
			backoff_interval <= `VMC_BACKOFF_RST;
			tenure_limit <= `VMC_TENURE_RST;
			release_policy <= `VMC_REL_RST;
			fair_request_mode <= 1'b0;
			request_level_select <= `VMC_LEVEL_RST;
		end else if (wr_pend) begin
			stop_request <= hwdata_in[`VMC_STOP_REQ];
			hold_request <= hwdata_in[`VMC_HOLD_REQ];
			atomic_cycle_enable <= hwdata_in[`VMC_ATOMIC];
			wide_addr_strobe_both <= hwdata_in[`VMC_WIDE_DS];
			backoff_interval <= hwdata_in[`VMC_BACKOFF_HI:`VMC_BACKOFF_LO];
			tenure_limit <= hwdata_in[`VMC_TENURE_HI:`VMC_TENURE_LO];
			release_policy <= hwdata_in[`VMC_REL_HI:`VMC_REL_LO];
			fair_request_mode <= hwdata_in[`VMC_FAIR];
			request_level_select <= hwdata_in[`VMC_LEVEL_HI:`VMC_LEVEL_LO];
		end
	end

	// zero-wait slave; unmapped reads give zero, writes dropped
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_pend <= 1'b0;
			hrdata_out <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			wr_pend <= 1'b0;
			if (hready_in && hsel_in && htrans_in[1]) begin
				wr_pend <= hwrite_in & addr_hit;
				if (!hwrite_in) begin
					hrdata_out <= addr_hit ? reg_value : 32'h0000_0000;
				end
			end
		end
	end

	// arbitration and datapath controls
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			initiator_grant_out <= 1'b0;
			bus_busy_out <= 1'b0;
			fair_mode_out <= 1'b0;
			data_strobe_out <= 2'b00;
			atomic_enable_out <= 1'b0;
			rmw_swap_write_out <= 1'b0;
		end else begin
			initiator_grant_out <= (next_state == ST_OWN) & ~stop_request &
				~local_reset;
			bus_busy_out <= (next_state == ST_OWN);
			fair_mode_out <= fair_request_mode;
			data_strobe_out <= (a64_addr_phase_in && wide_addr_strobe_both) ?
				2'b11 : data_strobe_sel_in;
			atomic_enable_out <= atomic_cycle_enable;
			rmw_swap_write_out <= atomic_cycle_enable & rmw_compare_done_in &
				rmw_match_in;
		end
	end

	// one request line per level
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : req_line
			always @(posedge mclk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					bus_req_out[g] <= 1'b0;
				end else begin
					bus_req_out[g] <= (next_state == ST_REQ) &&
						(request_level_select == g);
				end
			end
		end
	endgenerate

endmodule // vme_master_requester_control

`default_nettype wire

/* tb/requester_checker.sv */
// assertions on the requester's bus, strobe and atomic ports
// assumes one clock domain; bound into the design below
`timescale 1ns/1ps
`default_nettype none
module requester_checker (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic local_reset_input_n_in,
	input wire logic bus_grant_in,
	input wire logic [3:0] other_req_in,
	input wire logic [3:0] bus_req_out,
	input wire logic bus_busy_out,
	input wire logic fair_mode_out,
	input wire logic initiator_grant_out,
	input wire logic a64_addr_phase_in,
	input wire logic [1:0] data_strobe_sel_in,
	input wire logic [1:0] data_strobe_out,
	input wire logic rmw_compare_done_in,
	input wire logic rmw_match_in,
	input wire logic rmw_swap_write_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	AST_ONE_LINE: assert property (
		$onehot0(bus_req_out)) else $error("two request lines up");
	AST_BUSY_GRANT: assert property (
		$rose(bus_busy_out) |-> $past(bus_grant_in) && $past(|bus_req_out))
		else $error("bus taken without grant");
	AST_NO_REQ_BUSY: assert property (
		bus_busy_out |-> bus_req_out == 4'h0)
		else $error("request while owning bus");
	AST_INIT_OWN: assert property (
		initiator_grant_out |-> bus_busy_out)
		else $error("initiator let through without bus");
	AST_STROBE: assert property (
		!a64_addr_phase_in |=> data_strobe_out == $past(data_strobe_sel_in))
		else $error("strobes do not follow data phase");
	AST_SWAP: assert property (
		rmw_swap_write_out |-> $past(rmw_compare_done_in && rmw_match_in))
		else $error("swap without matching compare");
	AST_FAIR: assert property (
		$rose(|bus_req_out) && fair_mode_out |->
		($past(other_req_in) & bus_req_out) == 4'h0)
		else $error("fair request over a pending one");
	AST_LOCAL_RST: assert property (
		!local_reset_input_n_in |=> !bus_busy_out && bus_req_out == 4'h0
		&& !initiator_grant_out) else $error("bus kept in local reset");
	cover property ($rose(bus_busy_out));
	cover property (rmw_swap_write_out);
	cover property ($rose(|bus_req_out) && fair_mode_out);
endmodule // requester_checker
bind vme_master_requester_control requester_checker requester_checker_inst (.*);
`default_nettype wire

/* tb/bus_arbiter_model.sv */
// behavioural bus arbiter granting a raised request
// assumes requests are registered on the same clock
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter_model (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] req_in,
	input wire logic slow_in,
	output logic grant_out
);
	logic [2:0] age;
	// grant the cycle after a request line is up, late when slow
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			age <= 3'h0;
			grant_out <= 1'b0;
		end else begin
			age <= (req_in == 4'h0) ? 3'h0 : age + 3'h1;
			grant_out <= req_in != 4'h0 && (!slow_in || age == 3'h7);
		end
	end
endmodule // bus_arbiter_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench of the master requester control block
// assumes the arbiter model and a 40 MHz clock, 2 cycles a us
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [31:0] REG = 32'h0000_0234;
	logic mclk_in = 0, reset_n_in = 0, local_reset_input_n_in = 1;
	logic hsel_in = 1, hwrite_in = 0, hready_in, hreadyout_out, hresp_out;
	logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, q;
	logic [1:0] htrans_in = 0, data_strobe_sel_in = 0, data_strobe_out;
	logic [2:0] hsize_in = 3'h2;
	logic channel_req_in = 0, dma_req_in = 0, initiator_grant_out;
	logic bus_grant_in, bus_clear_in = 0, bus_busy_out, fair_mode_out;
	logic [3:0] other_req_in = 0, bus_req_out, beat_bytes_in = 0;
	logic xfer_2e_in = 0, beat_in = 0, a64_addr_phase_in = 0, slow = 0;
	logic rmw_compare_done_in = 0, rmw_match_in = 0;
	logic atomic_enable_out, rmw_swap_write_out;
	int n_errors = 0, checked = 0, n;
	assign hready_in = hreadyout_out;
	vme_master_requester_control #(.US_CYCLES(8'h02))
		vme_master_requester_control_inst (.*);
	bus_arbiter_model bus_arbiter_model_inst (.clk_in(mclk_in),
		.reset_n_in(reset_n_in), .req_in(bus_req_out), .slow_in(slow),
		.grant_out(bus_grant_in));
	initial begin
		forever #12.5 mclk_in = ~mclk_in;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, d);
		htrans_in <= 2'h2;
		haddr_in <= a;
		hwrite_in <= w;
		do @(posedge mclk_in); while (hready_in !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge mclk_in); while (hready_in !== 1'b1);
		q = hrdata_out;
	endtask
	task automatic wait_busy(input logic v);
		n = 0;
		while (bus_busy_out !== v && n < 400) begin
			@(posedge mclk_in);
			n++;
		end
		if (n >= 400) n_errors++;
	endtask
	task automatic pulse(input logic m);
		rmw_compare_done_in <= 1'b1;
		rmw_match_in <= m;
		@(posedge mclk_in);
		rmw_compare_done_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		stop_test;
	end
	initial begin
		repeat (20) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		@(posedge mclk_in);
		xfer(1'b0, REG, 32'h0000_0000);
		chk(q, 32'h0000_0003);
		xfer(1'b0, 32'h0000_0238, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		chk(hresp_out, 1'b0);
		slow <= 1'b1;
		xfer(1'b1, REG, 32'h0400_0003);
		repeat (2) @(posedge mclk_in);
		chk(bus_req_out, 4'h8);
		wait_busy(1'b1);
		channel_req_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		chk(initiator_grant_out, 1'b0);
		xfer(1'b0, REG, 32'h0000_0000);
		chk(q[27:24], 4'hC);
		repeat (20) @(posedge mclk_in);
		chk(bus_busy_out, 1'b1);
		channel_req_in <= 1'b0;
		xfer(1'b1, REG, 32'h0000_0003);
		wait_busy(1'b0);
		chk(bus_busy_out, 1'b0);
		slow <= 1'b0;
		xfer(1'b1, REG, 32'h0100_0001);
		wait_busy(1'b1);
		dma_req_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		chk(initiator_grant_out, 1'b1);
		xfer(1'b0, REG, 32'h0000_0000);
		chk(q[27:24], 4'h3);
		dma_req_in <= 1'b0;
		xfer(1'b1, REG, 32'h0000_0003);
		wait_busy(1'b0);
		other_req_in <= 4'h8;
		xfer(1'b1, REG, 32'h0400_0007);
		repeat (6) @(posedge mclk_in);
		chk(bus_req_out, 4'h0);
		chk(fair_mode_out, 1'b1);
		other_req_in <= 4'h0;
		wait_busy(1'b1);
		xfer(1'b1, REG, 32'h0011_0003);
		a64_addr_phase_in <= 1'b1;
		data_strobe_sel_in <= 2'h1;
		wait_busy(1'b0);
		chk(data_strobe_out, 2'h3);
		chk(atomic_enable_out, 1'b1);
		pulse(1'b1);
		chk(rmw_swap_write_out, 1'b1);
		pulse(1'b0);
		chk(rmw_swap_write_out, 1'b0);
		xfer(1'b1, REG, 32'h0000_0003);
		repeat (2) @(posedge mclk_in);
		chk(data_strobe_out, 2'h1);
		pulse(1'b1);
		chk(rmw_swap_write_out, 1'b0);
		channel_req_in <= 1'b1;
		xfer(1'b1, REG, 32'h0000_1003);
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk(n >= 7 && n <= 10, 1'b1);
		n = 0;
		while (bus_req_out === 4'h0 && n < 99) begin
			@(posedge mclk_in);
			n++;
		end
		chk(n >= 3 && n <= 5, 1'b1);
		xfer_2e_in <= 1'b1;
		beat_in <= 1'b1;
		beat_bytes_in <= 4'h8;
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk(n >= 15 && n <= 18, 1'b1);
		channel_req_in <= 1'b0;
		repeat (10) @(posedge mclk_in);
		xfer_2e_in <= 1'b0;
		beat_in <= 1'b0;
		xfer(1'b1, REG, 32'h0000_0013);
		channel_req_in <= 1'b1;
		wait_busy(1'b1);
		repeat (20) @(posedge mclk_in);
		chk(bus_busy_out, 1'b1);
		bus_clear_in <= 1'b1;
		wait_busy(1'b0);
		chk(n <= 3, 1'b1);
		bus_clear_in <= 1'b0;
		xfer(1'b1, REG, 32'h0000_000B);
		wait_busy(1'b1);
		repeat (20) @(posedge mclk_in);
		chk(bus_busy_out, 1'b1);
		other_req_in <= 4'h1;
		wait_busy(1'b0);
		chk(n <= 3, 1'b1);
		other_req_in <= 4'h0;
		xfer(1'b1, REG, 32'h0000_001B);
		wait_busy(1'b1);
		channel_req_in <= 1'b0;
		repeat (20) @(posedge mclk_in);
		chk(bus_busy_out, 1'b1);
		other_req_in <= 4'h1;
		wait_busy(1'b0);
		chk(n <= 3, 1'b1);
		other_req_in <= 4'h0;
		repeat (4) @(posedge mclk_in);
		xfer(1'b1, REG, 32'h0400_0003);
		wait_busy(1'b1);
		xfer(1'b0, REG, 32'h0000_0000);
		chk(q[27], 1'b1);
		local_reset_input_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		local_reset_input_n_in <= 1'b1;
		chk(bus_busy_out, 1'b0);
		xfer(1'b0, REG, 32'h0000_0000);
		chk(q, 32'h0000_0003);
		stop_test;
	end
endmodule // testbench
`default_nettype wire
